// *** hdl/clock_synth_serial_config.sv ***
// Serial configuration port and control registers of the clock synthesizer
`timescale 1ns/1ps
module clock_synth_serial_config
  import serial_cfg_pkg::*;
#(
  parameter int STEP_CYCLES = FREQ_STEP_CYC
)
(
  input  wire logic                               clock,
  input  wire logic                               rst_n,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [7:0]                         paddr,
  input  wire logic [31:0]                        pwdata,
  output logic [31:0]                             prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic                               serial_clock_pin,
  input  wire logic                               serial_data_pin,
  output logic                                    serial_data_out,
  output logic                                    serial_data_oe,
  input  wire logic [3:0]                         freq_strap,
  output logic [serial_cfg_pkg::RUN_OUTPUTS-1:0]  output_run,
  output logic                                    outputs_hiz,
  output logic                                    spread_on,
  output logic                                    freq_software,
  output logic [3:0]                              freq_code
);
  import serial_cfg_pkg::*;

  logic [7:0]  cfg [DATA_BYTES];
  logic        link_enable;
  logic        link_init;
  logic        link_clear;
  logic        framing;
  logic [1:0]  scl_sync;
  logic [1:0]  sda_sync;
  logic [4:0]  scl_hist;
  logic [2:0]  sda_hist;
  logic        scl_parked;
  logic        start_det;
  logic        stop_det;
  logic [1:0]  tog_sync;
  logic        tog_last;
  logic        byte_event;
  logic [7:0]  rx_data;
  logic [2:0]  rx_index;
  logic        rx_toggle;
  logic [15:0] loaded_count;
  logic [3:0]  strap_a;
  logic [3:0]  strap_b;
  logic [3:0]  freq_target;
  logic [15:0] ramp_timer;
  logic        access;
  logic        addr_ok;
  logic [31:0] next_prdata;

  // Receiver only ever drives the data line low
  assign serial_data_out = 1'b0;

  serial_byte_rx u_rx (
    .serial_clock_pin (serial_clock_pin),
    .link_init        (link_init),
    .link_clear       (link_clear),
    .serial_data_pin  (serial_data_pin),
    .serial_data_oe   (serial_data_oe),
    .byte_data        (rx_data),
    .byte_index       (rx_index),
    .byte_toggle      (rx_toggle)
  );

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_hist <= 5'h1f;
      sda_hist <= 3'h7;
      tog_sync <= 2'h0;
      tog_last <= 1'b0;
      strap_a  <= 4'h0;
      strap_b  <= 4'h0;
    end
    else
    begin
      scl_sync <= {scl_sync[0], serial_clock_pin};
      sda_sync <= {sda_sync[0], serial_data_pin};
      scl_hist <= {scl_hist[3:0], scl_sync[1]};
      sda_hist <= {sda_hist[1:0], sda_sync[1]};
      tog_sync <= {tog_sync[0], rx_toggle};
      tog_last <= tog_sync[1];
      strap_a  <= freq_strap;
      strap_b  <= strap_a;
    end
  end

  // Fast serial clock aliases here; six high samples only when it is parked
  assign scl_parked = scl_sync[1] && (&scl_hist);
  assign start_det  = scl_parked && sda_hist[2] && !sda_hist[1];
  assign stop_det   = scl_parked && !sda_hist[2] && sda_hist[1];
  assign byte_event = tog_sync[1] ^ tog_last;

  // Link side held cleared between frames and pulsed on a repeated start
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      link_init  <= 1'b1;
      framing    <= 1'b0;
      link_clear <= 1'b1;
    end
    else
    begin
      link_init  <= 1'b0;
      if (start_det && link_enable)
        framing <= 1'b1;
      else if (stop_det || !link_enable)
        framing <= 1'b0;
      link_clear <= start_det || stop_det || !framing;
    end
  end

  // Bytes stay stable for a whole byte time after the toggle, so no copy is needed
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DATA_BYTES; i++)
        cfg[i] <= CFG_DEFAULT[i];
      loaded_count <= 16'h0000;
    end
    else if (byte_event && link_enable)
    begin
      cfg[rx_index] <= rx_data;
      loaded_count  <= loaded_count + 16'h0001;
    end
  end

  // Reserved bits are stored as sent; the host keeps them zero
  assign output_run = {cfg[3][5:4], cfg[3][2:0], cfg[2][6], cfg[2][4:0],
                       cfg[1][3], cfg[1][1:0]};
  assign spread_on     = cfg[0][SPREAD_LSB +: 2] == SPREAD_ON;
  assign outputs_hiz   = cfg[0][SPREAD_LSB +: 2] == SPREAD_HIZ;
  assign freq_software = cfg[0][FREQ_SW_BIT];
  assign freq_target   = freq_software ?
                         {cfg[0][SEL3_BIT], cfg[0][SEL_LO_LSB +: 3]} : strap_b;

  // One code step per interval keeps the synthesizer from jumping
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      freq_code  <= 4'h0;
      ramp_timer <= 16'h0000;
    end
    else if (freq_code == freq_target)
      ramp_timer <= 16'h0000;
    else if (ramp_timer != 16'(STEP_CYCLES - 1))
      ramp_timer <= ramp_timer + 16'h0001;
    else
    begin
      ramp_timer <= 16'h0000;
      if (freq_target > freq_code)
        freq_code <= freq_code + 4'h1;
      else
        freq_code <= freq_code - 4'h1;
    end
  end

  // APB slave: zero wait states, read data captured in the setup phase
  assign access = psel && penable;
  assign pready = 1'b1;

  always_comb
  begin
    addr_ok     = 1'b1;
    next_prdata = 32'h0000_0000;
    if (paddr[1:0] != 2'h0)
      addr_ok = 1'b0;
    else if (paddr >= OFF_CFG0 && paddr <= OFF_CFG7)
    begin
      next_prdata = {24'h00_0000, cfg[paddr[4:2]]};
      addr_ok     = !pwrite;
    end
    else if (paddr == OFF_PORT_CTRL)
      next_prdata = {31'h0000_0000, link_enable};
    else if (paddr == OFF_STATUS)
      next_prdata = {loaded_count, 8'h00, 3'h0, freq_code, framing};
    else
      addr_ok = 1'b0;
  end

  assign pslverr = access && !addr_ok;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= addr_ok ? next_prdata : 32'h0000_0000;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      link_enable <= PORT_CTRL_RESET;
    else if (access && pwrite && paddr == OFF_PORT_CTRL)
      link_enable <= pwdata[0];
  end

  sequence byte_arrives;
    byte_event && link_enable;
  endsequence

  sequence frame_opens;
    start_det && link_enable;
  endsequence

  reset_default_a : assert property (@(posedge clock)
    $rose(rst_n) |-> cfg[0] == CFG_DEFAULT[0] && cfg[1] == CFG_DEFAULT[1]
      && cfg[2] == CFG_DEFAULT[2] && cfg[3] == CFG_DEFAULT[3])
    else $error("control bytes not at default after reset");

  byte_load_a : assert property (@(posedge clock) disable iff (!rst_n)
    byte_arrives |=> cfg[$past(rx_index)] == $past(rx_data))
    else $error("received byte not loaded");

  idle_hold_a : assert property (@(posedge clock) disable iff (!rst_n)
    !byte_event |=> $stable(loaded_count))
    else $error("registers changed without a byte");

  frame_clear_a : assert property (@(posedge clock) disable iff (!rst_n)
    frame_opens |=> link_clear ##1 framing)
    else $error("start condition did not restart the link");

  step_size_a : assert property (@(posedge clock) disable iff (!rst_n)
    !$stable(freq_code) |-> freq_code == $past(freq_code) + 4'h1
      || freq_code == $past(freq_code) - 4'h1)
    else $error("frequency code jumped");

  step_spacing_a : assert property (@(posedge clock) disable iff (!rst_n)
    !$stable(freq_code) |-> $past(ramp_timer) == 16'(STEP_CYCLES - 1))
    else $error("frequency step too early");

  spread_field_a : assert property (@(posedge clock) disable iff (!rst_n)
    byte_arrives ##1 (rx_index == 3'h0 && rx_data[1:0] == SPREAD_ON)
      |=> spread_on && !outputs_hiz)
    else $error("spread enable not applied");

  hiz_field_a : assert property (@(posedge clock) disable iff (!rst_n)
    (cfg[0][1:0] == SPREAD_HIZ) |-> outputs_hiz && !spread_on)
    else $error("three-state selection not applied");

  disable_low_a : assert property (@(posedge clock) disable iff (!rst_n)
    byte_arrives ##1 (rx_index == 3'h1 && !rx_data[0]) |=> !output_run[0])
    else $error("disabled output still running");

  write_only_a : assert property (@(posedge clock) disable iff (!rst_n)
    access && pwrite && paddr <= OFF_CFG7 && paddr[1:0] == 2'h0 |-> pslverr)
    else $error("control byte accepted a bus write");
endmodule : clock_synth_serial_config

// *** hdl/serial_cfg_pkg.sv ***
// Constants shared by the serial configuration receiver and its control block
package serial_cfg_pkg;
  localparam logic [7:0] SLAVE_ADDR      = 8'hd2;
  localparam int         HEADER_BYTES    = 3;
  localparam int         DATA_BYTES      = 8;
  localparam int         FRAME_BYTES     = 11;
  localparam logic [3:0] BIT_ACK         = 4'h8;
  localparam logic [3:0] BYTE_HDR_LAST   = 4'h2;
  localparam logic [3:0] BYTE_DATA_LAST  = 4'ha;
  localparam logic [3:0] BYTE_OVERFLOW   = 4'hc;
  localparam logic [7:0] CFG_DEFAULT [8] = '{8'h00, 8'h0b, 8'h5f, 8'h37,
                                             8'h00, 8'h00, 8'h00, 8'h00};
  localparam int         SPREAD_LSB      = 0;
  localparam int         FREQ_SW_BIT     = 3;
  localparam int         SEL3_BIT        = 2;
  localparam int         SEL_LO_LSB      = 4;
  localparam logic [1:0] SPREAD_OFF      = 2'h0;
  localparam logic [1:0] SPREAD_ON       = 2'h2;
  localparam logic [1:0] SPREAD_HIZ      = 2'h3;
  localparam int         CLOCK_NS        = 40;
  localparam int         FREQ_STEP_NS    = 1000;
  localparam int         FREQ_STEP_CYC   = (FREQ_STEP_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam logic [7:0] OFF_CFG0        = 8'h00;
  localparam logic [7:0] OFF_CFG7        = 8'h1c;
  localparam logic [7:0] OFF_PORT_CTRL   = 8'h20;
  localparam logic [7:0] OFF_STATUS      = 8'h24;
  localparam logic       PORT_CTRL_RESET = 1'b1;
  localparam int         RUN_OUTPUTS     = 14;
endpackage : serial_cfg_pkg

// *** hdl/serial_byte_rx.sv ***
// Link-side byte receiver, clocked by the host's serial clock
`timescale 1ns/1ps
module serial_byte_rx
  import serial_cfg_pkg::*;
(
  input  wire logic       serial_clock_pin,
  input  wire logic       link_init,
  input  wire logic       link_clear,
  input  wire logic       serial_data_pin,
  output logic            serial_data_oe,
  output logic [7:0]      byte_data,
  output logic [2:0]      byte_index,
  output logic            byte_toggle
);
  logic [3:0] bit_cnt;
  logic [3:0] byte_num;
  logic [6:0] shift;
  logic       addressed;
  logic [7:0] next_byte;
  logic       clear_any;

  assign clear_any = link_clear | link_init;
  assign next_byte = {shift, serial_data_pin};

  // Link clock only runs inside frames, so the frame edges reset this side
  always_ff @(posedge serial_clock_pin or posedge clear_any)
  begin
    if (clear_any)
    begin
      bit_cnt   <= 4'h0;
      byte_num  <= 4'h0;
      shift     <= 7'h00;
      addressed <= 1'b0;
    end
    else if (bit_cnt == BIT_ACK)
      bit_cnt <= 4'h0;
    else
    begin
      shift   <= next_byte[6:0];
      bit_cnt <= bit_cnt + 4'h1;
      if (bit_cnt == 4'h7)
      begin
        if (byte_num == 4'h0)
          addressed <= (next_byte == SLAVE_ADDR);
        if (byte_num != BYTE_OVERFLOW)
          byte_num <= byte_num + 4'h1;
      end
    end
  end

  // Header bytes two and three are dropped; only data bytes are forwarded
  always_ff @(posedge serial_clock_pin or posedge link_init)
  begin
    if (link_init)
    begin
      byte_data   <= 8'h00;
      byte_index  <= 3'h0;
      byte_toggle <= 1'b0;
    end
    else if (bit_cnt == 4'h7 && addressed && byte_num > BYTE_HDR_LAST
             && byte_num <= BYTE_DATA_LAST)
    begin
      byte_data   <= next_byte;
      byte_index  <= 3'(byte_num - 4'h3);
      byte_toggle <= ~byte_toggle;
    end
  end

  // Acknowledge driven from the falling edge so it is settled at the rise
  always_ff @(negedge serial_clock_pin or posedge clear_any)
  begin
    if (clear_any)
      serial_data_oe <= 1'b0;
    else
      serial_data_oe <= (bit_cnt == BIT_ACK) && addressed
                        && (byte_num <= 4'(FRAME_BYTES));
  end

  addr_reject_a : assert property (@(posedge serial_clock_pin) disable iff (clear_any)
    (bit_cnt == 4'h7 && byte_num == 4'h0 && next_byte != SLAVE_ADDR) |=> !addressed)
    else $error("address mismatch still addressed");

  ack_owner_a : assert property (@(posedge serial_clock_pin) disable iff (clear_any)
    serial_data_oe |-> addressed && bit_cnt == BIT_ACK)
    else $error("acknowledge without address match");
endmodule : serial_byte_rx

// *** testbench/serial_host_model.sv ***
// Bus master model that writes configuration frames over the two pins
`timescale 1ns/1ps
module serial_host_model
(
  output logic      serial_clock_pin,
  output wire logic serial_data_pin,
  input  wire logic serial_data_oe
);
  logic host_sda;

  // Pull-up on the data line: released reads high unless the device pulls low
  assign serial_data_pin = host_sda & ~serial_data_oe;

  // Clock stands high between frames
  initial
  begin
    serial_clock_pin = 1'b1;
    host_sda = 1'b1;
  end

  // Long holds around start and stop so the system domain sees both edges
  task automatic send_frame(input logic [7:0] f [11], input int n, output int acks);
    begin
      acks = 0;
      #200 host_sda = 1'b0;
      #400;
      for (int i = 0; i < n; i++)
      begin
        for (int b = 7; b >= -1; b--)
        begin
          serial_clock_pin = 1'b0;
          #7 host_sda = (b < 0) ? 1'b1 : f[i][b & 7];
          #8 serial_clock_pin = 1'b1;
          if (b < 0 && serial_data_pin === 1'b0)
            acks++;
          #15;
        end
      end
      serial_clock_pin = 1'b0;
      #7 host_sda = 1'b0;
      #8 serial_clock_pin = 1'b1;
      #200 host_sda = 1'b1;
      #200;
    end
  endtask : send_frame
endmodule : serial_host_model

// *** testbench/clock_synth_serial_config_test.sv ***
// Register-level test of the serial configuration port
`timescale 1ns/1ps
module clock_synth_serial_config_test;
  import serial_cfg_pkg::*;
  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        serial_clock_pin, serial_data_pin, serial_data_oe, serial_data_out, err;
  logic [3:0]  freq_strap, freq_code, prev_fc;
  logic [13:0] output_run;
  logic        outputs_hiz, spread_on, freq_software;
  int          error_cnt, compares, acks;
  // Three-state, off, then software frequency select of code 0xc
  logic [7:0]  e3 [3] = '{8'h03, 8'h00, 8'h4c};

  clock_synth_serial_config #(.STEP_CYCLES(2)) clock_synth_serial_config_i
  (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_pin(serial_clock_pin), .serial_data_pin(serial_data_pin),
    .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe), .freq_strap(freq_strap),
    .output_run(output_run), .outputs_hiz(outputs_hiz), .spread_on(spread_on),
    .freq_software(freq_software), .freq_code(freq_code)
  );

  serial_host_model serial_host_model_i
  (
    .serial_clock_pin(serial_clock_pin),
    .serial_data_pin(serial_data_pin),
    .serial_data_oe(serial_data_oe)
  );

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      compares++;
      if (seen !== exp)
      begin
        error_cnt++;
        $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask : check

  task automatic complete_run();
    begin
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask : complete_run

  // Entered just after a rising edge; zero wait states are not assumed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1)
        @(posedge clock);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
    end
  endtask : apb

  task automatic send(input logic [7:0] a, b0, b1, b2, b3);
    logic [7:0] f [11];
    begin
      f = '{a, 8'h5a, 8'h3c, b0, b1, b2, b3, 8'h00, 8'h00, 8'h00, 8'h00};
      serial_host_model_i.send_frame(f, 11, acks);
      repeat (10) @(posedge clock);
    end
  endtask : send

  task automatic check_cfg(input logic [7:0] b0, b1, b2, b3);
    logic [7:0] e [8];
    begin
      e = '{b0, b1, b2, b3, 8'h00, 8'h00, 8'h00, 8'h00};
      for (int k = 0; k < 8; k++)
      begin
        apb(1'b0, 8'(4 * k), 32'h0);
        check(rd, {24'h0, e[k]});
      end
      check(output_run, {b3[5:4], b3[2:0], b2[6], b2[4:0], b1[3], b1[1:0]});
      check({spread_on, outputs_hiz}, {b0[1:0] == 2'b10, b0[1:0] == 2'b11});
      check(freq_software, b0[3]);
    end
  endtask : check_cfg

  // Frequency code must only ever move by one step
  always @(posedge clock)
  begin
    if (rst_n === 1'b1 && freq_code !== prev_fc)
      check(32'(freq_code == prev_fc + 4'h1 || freq_code == prev_fc - 4'h1), 32'h1);
    prev_fc <= freq_code;
  end

  initial
  begin
    #500000;
    error_cnt++;
    complete_run();
  end

  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    freq_strap = 4'h3;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (40) @(posedge clock);
    check_cfg(8'h00, 8'h0b, 8'h5f, 8'h37);
    check(freq_code, 4'h3);
    apb(1'b1, 8'h00, 32'hff);
    check(err, 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    check({err, rd}, {1'b1, 32'h0});
    check(serial_data_out, 1'b0);
    send(8'hd0, 8'h02, 8'h00, 8'h00, 8'h00);
    check(acks, 0);
    check_cfg(8'h00, 8'h0b, 8'h5f, 8'h37);
    send(SLAVE_ADDR, 8'h02, 8'h0a, 8'h54, 8'h32);
    check(acks, 11);
    check_cfg(8'h02, 8'h0a, 8'h54, 8'h32);
    foreach (e3[i])
    begin
      send(SLAVE_ADDR, e3[i], 8'h0b, 8'h5f, 8'h37);
      check_cfg(e3[i], 8'h0b, 8'h5f, 8'h37);
    end
    repeat (60) @(posedge clock);
    check(freq_code, 4'hc);
    apb(1'b0, 8'h24, 32'h0);
    check(rd, 32'h0020_0018);
    apb(1'b1, 8'h20, 32'h0);
    send(SLAVE_ADDR, 8'h02, 8'h0b, 8'h5f, 8'h37);
    check(acks, 0);
    check_cfg(8'h4c, 8'h0b, 8'h5f, 8'h37);
    apb(1'b1, 8'h20, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h1);
    send(SLAVE_ADDR, 8'h08, 8'h0b, 8'h5f, 8'h37);
    check(acks, 11);
    repeat (60) @(posedge clock);
    check(freq_code, 4'h0);
    complete_run();
  end

endmodule : clock_synth_serial_config_test
